// File: design/rsim_pkg.sv
// Register map, field positions, reset values and carrier types for the regulator status bank
package rsim_pkg;

    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 8;

    // Register offsets
    localparam logic [7:0] ADDR_TOP_FLAG   = 8'h1a;
    localparam logic [7:0] ADDR_SW_STATUS  = 8'h1e;
    localparam logic [7:0] ADDR_LIN_STATUS = 8'h1f;
    localparam logic [7:0] ADDR_TOP_MASK   = 8'h20;

    // Reset values
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [7:0] FLAG_RESET   = 8'h00;
    localparam logic [7:0] MASK_RESET   = 8'h90;
    localparam logic [7:0] READ_ZERO    = 8'h00;

    // Regulator status field positions
    localparam int unsigned BIT_EN1  = 7;
    localparam int unsigned BIT_INV1 = 6;
    localparam int unsigned BIT_RSV1 = 5;
    localparam int unsigned BIT_LIM1 = 4;
    localparam int unsigned BIT_EN0  = 3;
    localparam int unsigned BIT_INV0 = 2;
    localparam int unsigned BIT_RSV0 = 1;
    localparam int unsigned BIT_LIM0 = 0;

    // Top-level event positions, shared by mask and flag registers
    localparam int unsigned BIT_POWER_OK  = 7;
    localparam int unsigned BIT_SYNC_CLK  = 4;
    localparam int unsigned BIT_HOT_DIE   = 2;
    localparam int unsigned BIT_LOAD_MEAS = 0;

    localparam int unsigned SYNC_W = 16;

    typedef struct packed {
        logic enabled1;
        logic vout_invalid1;
        logic limiting1;
        logic enabled0;
        logic vout_invalid0;
        logic limiting0;
    } rsim_rail_t;

    typedef struct packed {
        logic power_ok_pin_state;
        logic sync_clk_invalid;
        logic hot_die_state;
        logic load_meas_ready;
    } rsim_top_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } rsim_req_t;

endpackage

// File: design/rsim_sync.sv
// Two-flop synchroniser for a bundle of detector levels
`timescale 1ns/1ps
module rsim_sync #(
    parameter int unsigned W = 16
) (
    input  wire logic         core_clk_i,
    input  wire logic         sys_rst_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    logic [W-1:0] meta;

    // First stage feeds only the second stage
    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            meta <= '0;
            q_o  <= '0;
        end else begin
            meta <= d_i;
            q_o  <= meta;
        end
    end
endmodule

// File: design/rsim_regs.sv
// Regulator status, top mask and event flag registers behind the register port
//
// What this block does
// - Switching status bit 7 and bit 3: regulator one and zero enabled.
// - Switching status bits 6 and 2: unlatched output voltage invalid, one and zero.
// - Switching status bits 4 and 0: unlatched current limit active, one and zero.
// - Linear status bits 7 and 3: linear regulator one and zero enabled.
// - Linear status bits 6 and 2: unlatched output voltage invalid.
// - Linear status bits 4 and 0: unlatched current limit active.
// - Linear status at 0x1F is read-only, all fields read 0 after reset.
// - Top mask at 0x20 is read-write, reserved bits reset to 0.
// - Mask bit 7 blocks power-good pin interrupt, resets to 1.
// - Mask bit 4 blocks sync clock detection interrupt, resets to 1.
// - Mask bit 2 blocks die thermal warning interrupt, resets to 0.
// - Mask bit 0 blocks load measurement ready interrupt, resets to 0.
// - Masks only block interrupts; raw status keeps tracking conditions.
// - Events set latched flags; host clears a flag by writing 1.
`timescale 1ns/1ps
module rsim_regs (
    input  wire logic                 core_clk_i,
    input  wire logic                 sys_rst_i,
    input  wire rsim_pkg::rsim_rail_t sw_reg_raw_i,
    input  wire rsim_pkg::rsim_rail_t lin_reg_raw_i,
    input  wire rsim_pkg::rsim_top_t  top_raw_i,
    input  wire rsim_pkg::rsim_req_t  reg_req_i,
    output logic [7:0]                reg_rdata_o,
    output logic                      reg_rvalid_o,
    output logic                      irq_o
);
    rsim_pkg::rsim_rail_t sw_s;
    rsim_pkg::rsim_rail_t lin_s;
    rsim_pkg::rsim_top_t  top_s;
    rsim_pkg::rsim_top_t  top_prev;
    logic [rsim_pkg::SYNC_W-1:0] sync_q;
    logic [7:0]           mask;
    logic [7:0]           flag;
    logic [7:0]           ev_vec;
    logic [7:0]           clr_vec;
    logic [7:0]           next_flag;
    logic [7:0]           rd_mux;
    logic                 mask_we;
    logic                 flag_we;
    logic                 next_irq;

    // Place the six rail fields into their byte positions
    function automatic logic [7:0] pack_rail(input rsim_pkg::rsim_rail_t r);
        logic [7:0] b;
        b = rsim_pkg::STATUS_RESET;
        b[rsim_pkg::BIT_EN1]  = r.enabled1;
        b[rsim_pkg::BIT_INV1] = r.vout_invalid1;
        b[rsim_pkg::BIT_LIM1] = r.limiting1;
        b[rsim_pkg::BIT_EN0]  = r.enabled0;
        b[rsim_pkg::BIT_INV0] = r.vout_invalid0;
        b[rsim_pkg::BIT_LIM0] = r.limiting0;
        return b;
    endfunction

    // Detector levels are asynchronous to the core; sync before use
    rsim_sync #(
        .W (rsim_pkg::SYNC_W)
    ) u_sync (
        .core_clk_i (core_clk_i),
        .sys_rst_i  (sys_rst_i),
        .d_i        ({sw_reg_raw_i, lin_reg_raw_i, top_raw_i}),
        .q_o        (sync_q)
    );

    assign {sw_s, lin_s, top_s} = sync_q;

    assign mask_we = reg_req_i.wr && (reg_req_i.addr == rsim_pkg::ADDR_TOP_MASK);
    assign flag_we = reg_req_i.wr && (reg_req_i.addr == rsim_pkg::ADDR_TOP_FLAG);
    assign clr_vec = flag_we ? reg_req_i.wdata : rsim_pkg::FLAG_RESET;

    // Pin and clock status report both directions; thermal and measurement only on rise
    always_comb begin
        ev_vec = rsim_pkg::FLAG_RESET;
        ev_vec[rsim_pkg::BIT_POWER_OK]  = top_s.power_ok_pin_state ^ top_prev.power_ok_pin_state;
        ev_vec[rsim_pkg::BIT_SYNC_CLK]  = top_s.sync_clk_invalid ^ top_prev.sync_clk_invalid;
        ev_vec[rsim_pkg::BIT_HOT_DIE]   = top_s.hot_die_state & ~top_prev.hot_die_state;
        ev_vec[rsim_pkg::BIT_LOAD_MEAS] = top_s.load_meas_ready & ~top_prev.load_meas_ready;
    end

    // Set wins over a same-cycle write-1 clear, so no event is lost
    genvar gi;
    generate
        for (gi = 0; gi < rsim_pkg::DATA_W; gi++) begin : g_flag
            assign next_flag[gi] = ev_vec[gi] | (flag[gi] & ~clr_vec[gi]);
        end
    endgenerate

    // Flags latch regardless of mask; the mask only gates the interrupt line
    assign next_irq = |(flag & ~mask);

    // Status reads come straight from synced levels; nothing clears on read
    wire sel_sw   = (reg_req_i.addr == rsim_pkg::ADDR_SW_STATUS);
    wire sel_lin  = (reg_req_i.addr == rsim_pkg::ADDR_LIN_STATUS);
    wire sel_mask = (reg_req_i.addr == rsim_pkg::ADDR_TOP_MASK);
    wire sel_flag = (reg_req_i.addr == rsim_pkg::ADDR_TOP_FLAG);

    assign rd_mux = sel_sw   ? pack_rail(sw_s)  :
                    sel_lin  ? pack_rail(lin_s) :
                    sel_mask ? mask :
                    sel_flag ? flag :
                    rsim_pkg::READ_ZERO;

    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            top_prev <= '0;
            flag     <= rsim_pkg::FLAG_RESET;
            irq_o    <= 1'b0;
        end else begin
            top_prev <= top_s;
            flag     <= next_flag;
            irq_o    <= next_irq;
        end
    end

    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            mask <= rsim_pkg::MASK_RESET;
        end else if (mask_we) begin
            mask <= reg_req_i.wdata;
        end
    end

    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            reg_rdata_o  <= rsim_pkg::READ_ZERO;
            reg_rvalid_o <= 1'b0;
        end else begin
            reg_rdata_o  <= reg_req_i.rd ? rd_mux : reg_rdata_o;
            reg_rvalid_o <= reg_req_i.rd;
        end
    end

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (sys_rst_i);

    wire rd_sw   = reg_req_i.rd && sel_sw;
    wire rd_lin  = reg_req_i.rd && sel_lin;
    wire rd_mask = reg_req_i.rd && sel_mask;
    wire rd_flag = reg_req_i.rd && sel_flag;
    wire rd_none = reg_req_i.rd && !(sel_sw || sel_lin || sel_mask || sel_flag);

    // An event counts as unmasked only if no mask write races it
    sequence s_unmasked_event(int unsigned b);
        ev_vec[b] && !mask[b] && !mask_we;
    endsequence

    // A write-1 clear that no new event overrides
    sequence s_flag_cleared(int unsigned b);
        flag_we && reg_req_i.wdata[b] && !ev_vec[b];
    endsequence

    // Status reads answer one cycle later with the synced levels
    chk_sw_enable: assert property (rd_sw |=> reg_rvalid_o &&
        reg_rdata_o[7] == $past(sw_s.enabled1) && reg_rdata_o[3] == $past(sw_s.enabled0))
        else $error("switching enable bits wrong");
    chk_sw_vout: assert property (rd_sw |=>
        reg_rdata_o[6] == $past(sw_s.vout_invalid1) && reg_rdata_o[2] == $past(sw_s.vout_invalid0))
        else $error("switching vout bits wrong");
    chk_sw_limit: assert property (rd_sw |=>
        reg_rdata_o[4] == $past(sw_s.limiting1) && reg_rdata_o[0] == $past(sw_s.limiting0))
        else $error("switching limit bits wrong");
    chk_sw_reserved: assert property (rd_sw |=> !reg_rdata_o[5] && !reg_rdata_o[1])
        else $error("switching reserved bits not zero");
    chk_lin_fields: assert property (rd_lin |=> reg_rvalid_o &&
        reg_rdata_o[7] == $past(lin_s.enabled1) &&
        reg_rdata_o[3] == $past(lin_s.enabled0))
        else $error("linear enable bits wrong");
    chk_lin_vout: assert property (rd_lin |=>
        reg_rdata_o[6] == $past(lin_s.vout_invalid1) &&
        reg_rdata_o[2] == $past(lin_s.vout_invalid0))
        else $error("linear vout bits wrong");
    chk_lin_limit: assert property (rd_lin |=>
        reg_rdata_o[4] == $past(lin_s.limiting1) &&
        reg_rdata_o[0] == $past(lin_s.limiting0))
        else $error("linear limit bits wrong");
    chk_lin_reserved: assert property (rd_lin |=> !reg_rdata_o[5] && !reg_rdata_o[1])
        else $error("linear reserved bits not zero");
    chk_unmapped_zero: assert property (rd_none |=> reg_rdata_o == rsim_pkg::READ_ZERO)
        else $error("unmapped read not zero");
    chk_rvalid_pulse: assert property (1'b1 |=> reg_rvalid_o == $past(reg_req_i.rd))
        else $error("read answer not one cycle after request");
    chk_rdata_hold: assert property (!reg_req_i.rd |=> $stable(reg_rdata_o))
        else $error("read data moved without a read");

    // Mask register stores what is written and nothing else
    chk_mask_write: assert property (mask_we |=> mask == $past(reg_req_i.wdata))
        else $error("mask write not stored");
    chk_mask_hold: assert property (!mask_we |=> $stable(mask))
        else $error("mask changed without a write");
    chk_mask_read: assert property (rd_mask |=> reg_rdata_o == $past(mask))
        else $error("mask read back wrong");

    // Interrupt path: flag one edge after the event, line one edge later
    chk_power_ok_irq: assert property (
        s_unmasked_event(rsim_pkg::BIT_POWER_OK) |-> ##2 irq_o)
        else $error("power-ok event gave no interrupt");
    chk_sync_clk_irq: assert property (
        s_unmasked_event(rsim_pkg::BIT_SYNC_CLK) |-> ##2 irq_o)
        else $error("sync clock event gave no interrupt");
    chk_hot_die_irq: assert property (
        s_unmasked_event(rsim_pkg::BIT_HOT_DIE) |-> ##2 irq_o)
        else $error("thermal event gave no interrupt");
    chk_load_meas_irq: assert property (
        s_unmasked_event(rsim_pkg::BIT_LOAD_MEAS) |-> ##2 irq_o)
        else $error("measurement event gave no interrupt");
    chk_masked_quiet: assert property ((flag & ~mask) == 8'h00 |=> !irq_o)
        else $error("masked flags raised interrupt");
    chk_irq_follows: assert property ((flag & ~mask) != 8'h00 |=> irq_o)
        else $error("unmasked flag gave no interrupt");
    chk_mask_no_status: assert property ((ev_vec & mask) != 8'h00 |=>
        (flag & $past(ev_vec & mask)) == $past(ev_vec & mask))
        else $error("masked event did not latch");

    // Flags: set beats a same-cycle clear, write 1 clears otherwise
    chk_flag_set_wins: assert property (
        ev_vec[rsim_pkg::BIT_HOT_DIE] |=> flag[rsim_pkg::BIT_HOT_DIE])
        else $error("event lost against clear");
    chk_flag_clear: assert property (
        s_flag_cleared(rsim_pkg::BIT_LOAD_MEAS) |=> !flag[rsim_pkg::BIT_LOAD_MEAS])
        else $error("write one did not clear flag");
    chk_hot_die_clear: assert property (
        s_flag_cleared(rsim_pkg::BIT_HOT_DIE) |=> !flag[rsim_pkg::BIT_HOT_DIE])
        else $error("write one did not clear thermal flag");
    chk_power_ok_clear: assert property (
        s_flag_cleared(rsim_pkg::BIT_POWER_OK) |=> !flag[rsim_pkg::BIT_POWER_OK])
        else $error("write one did not clear power-ok flag");
    chk_sync_clk_clear: assert property (
        s_flag_cleared(rsim_pkg::BIT_SYNC_CLK) |=> !flag[rsim_pkg::BIT_SYNC_CLK])
        else $error("write one did not clear sync clock flag");
    chk_flag_read: assert property (rd_flag |=> reg_rdata_o == $past(flag))
        else $error("flag read back wrong");
    chk_read_no_clear: assert property (
        reg_req_i.rd && !flag_we && ev_vec == 8'h00 |=> flag == $past(flag))
        else $error("read changed flags");
endmodule

// File: test/rsim_host_model.sv
// Host-side model that issues register requests and collects read answers
`timescale 1ns/1ps
module rsim_host_model (
    input  wire logic           core_clk_i,
    input  wire logic [7:0]     reg_rdata_i,
    input  wire logic           reg_rvalid_i,
    output rsim_pkg::rsim_req_t reg_req_o
);
    initial reg_req_o = '{1'b0, 1'b0, 8'h5a, 8'ha5};
    // Released lines flip so a stale address or data never looks valid
    // Writing 1 to a flag bit clears it
    task automatic write(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk_i);
        reg_req_o <= '{1'b1, 1'b0, a, d};
        @(posedge core_clk_i);
        reg_req_o <= '{1'b0, 1'b0, ~a, ~d};
    endtask
    // Answer is sampled exactly one edge after the taking edge
    task automatic read(input logic [7:0] a, output logic [7:0] d, output logic ok);
        @(posedge core_clk_i);
        reg_req_o <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge core_clk_i);
        reg_req_o <= '{1'b0, 1'b0, ~a, 8'hff};
        @(posedge core_clk_i);
        ok = (reg_rvalid_i === 1'b1);
        d  = reg_rdata_i;
    endtask
endmodule

// File: test/tb_top.sv
// Random and directed checks of the regulator status bank
`timescale 1ns/1ps
module tb_top;
    logic                 core_clk_i = 1'b0;
    logic                 sys_rst_i  = 1'b1;
    rsim_pkg::rsim_rail_t sw_raw     = '0;
    rsim_pkg::rsim_rail_t lin_raw    = '0;
    rsim_pkg::rsim_top_t  top_raw    = '0;
    rsim_pkg::rsim_req_t  req;
    logic [7:0]           rdata;
    logic                 rvalid;
    logic                 irq;
    logic [7:0]           got;
    logic [7:0]           m;
    logic                 ok;
    int                   errors = 0;
    int                   samples_checked = 0;
    int                   seed = 32'h2da0f9d3;

    always #50 core_clk_i = ~core_clk_i;

    rsim_regs rsim_regs_i (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
        .sw_reg_raw_i(sw_raw), .lin_reg_raw_i(lin_raw), .top_raw_i(top_raw),
        .reg_req_i(req), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid), .irq_o(irq));
    rsim_host_model rsim_host_model_i (.core_clk_i(core_clk_i), .reg_rdata_i(rdata),
        .reg_rvalid_i(rvalid), .reg_req_o(req));

    function automatic logic [7:0] pack(input rsim_pkg::rsim_rail_t r);
        return {r.enabled1, r.vout_invalid1, 1'b0, r.limiting1,
                r.enabled0, r.vout_invalid0, 1'b0, r.limiting0};
    endfunction
    // Top source positions in the carrier differ from the mask layout
    function automatic logic [7:0] mbit(input int j);
        return (j == 3) ? 8'h80 : (j == 2) ? 8'h10 : (j == 1) ? 8'h04 : 8'h01;
    endfunction

    task automatic conclude();
        if (errors == 0 && samples_checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk_data(input logic [7:0] e, input logic [7:0] g);
        samples_checked++;
        if (g !== e) begin
            errors++;
            $display("Error t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    task automatic chk_irq(input logic e);
        samples_checked++;
        if (irq !== e) begin
            errors++;
            $display("Error t=%0t exp=%h got=%h", $time, e, irq);
        end
    endtask
    task automatic chk_valid(input logic g);
        samples_checked++;
        if (g !== 1'b1) begin
            errors++;
            $display("Error t=%0t exp=%h got=%h", $time, 1'b1, g);
        end
    endtask
    // A missing answer is a hang in disguise, so it ends the run
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        rsim_host_model_i.read(a, got, ok);
        chk_valid(ok);
        if (!ok) conclude();
        else chk_data(e, got);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        rsim_host_model_i.write(a, d);
    endtask
    task automatic ticks(input int n);
        repeat (n) @(posedge core_clk_i);
    endtask

    initial begin
        #2000000;
        errors++;
        conclude();
    end

    initial begin
        ticks(8);
        sys_rst_i <= 1'b0;
        ticks(1);
        chk_irq(1'b0);
        rd(rsim_pkg::ADDR_SW_STATUS, 8'h00);
        rd(rsim_pkg::ADDR_LIN_STATUS, 8'h00);
        rd(rsim_pkg::ADDR_TOP_MASK, 8'h90);
        rd(8'h55, 8'h00);
        for (int i = 0; i < 24; i++) begin
            @(posedge core_clk_i);
            sw_raw  <= (i == 0) ? 6'h3f : 6'($random(seed));
            lin_raw <= (i == 1) ? 6'h3f : 6'($random(seed));
            ticks(3);
            rd(rsim_pkg::ADDR_SW_STATUS, pack(sw_raw));
            rd(rsim_pkg::ADDR_LIN_STATUS, pack(lin_raw));
            rd(rsim_pkg::ADDR_LIN_STATUS, pack(lin_raw));
        end
        wr(rsim_pkg::ADDR_LIN_STATUS, 8'hff);
        rd(rsim_pkg::ADDR_LIN_STATUS, pack(lin_raw));
        wr(rsim_pkg::ADDR_SW_STATUS, 8'hff);
        rd(rsim_pkg::ADDR_SW_STATUS, pack(sw_raw));
        for (int i = 0; i < 6; i++) begin
            m = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : 8'($random(seed));
            wr(rsim_pkg::ADDR_TOP_MASK, m);
            rd(rsim_pkg::ADDR_TOP_MASK, m);
        end
        for (int j = 0; j < 4; j++) begin
            m = mbit(j);
            wr(rsim_pkg::ADDR_TOP_MASK, ~m);
            wr(rsim_pkg::ADDR_TOP_FLAG, 8'hff);
            @(posedge core_clk_i);
            top_raw <= 4'(4'h1 << j);
            ticks(6);
            chk_irq(1'b1);
            rd(rsim_pkg::ADDR_TOP_FLAG, m);
            wr(rsim_pkg::ADDR_TOP_MASK, 8'hff);
            ticks(2);
            chk_irq(1'b0);
            rd(rsim_pkg::ADDR_TOP_FLAG, m);
            wr(rsim_pkg::ADDR_TOP_MASK, ~m);
            ticks(2);
            chk_irq(1'b1);
            wr(rsim_pkg::ADDR_TOP_FLAG, m);
            ticks(2);
            chk_irq(1'b0);
            rd(rsim_pkg::ADDR_TOP_FLAG, 8'h00);
            @(posedge core_clk_i);
            top_raw <= '0;
            ticks(6);
        end
        conclude();
    end
endmodule
